// File: rtl/ssf_map.vh
// Constants for the serial port status flags block: offsets, fields, reset values.
// Assumes a byte-wide register port; included by bare name.
`ifndef SSF_MAP_VH
`define SSF_MAP_VH
`define SSF_ADDR_W        4
`define SSF_OFF_STATUS    4'h0
`define SSF_OFF_CTRL      4'h1
`define SSF_OFF_EVENT     4'h2
`define SSF_OFF_ADDR      4'h3
`define SSF_OFF_BUF       4'h4
`define SSF_BIT_START     3
`define SSF_BIT_DIR       2
`define SSF_BIT_UPD       1
`define SSF_BIT_FULL      0
`define SSF_CTRL_EN       0
`define SSF_CTRL_I2C      1
`define SSF_CTRL_MASTER   2
`define SSF_CTRL_ADDR10   3
`define SSF_CTRL_START    4
`define SSF_CTRL_RSTART   5
`define SSF_CTRL_STOP     6
`define SSF_CTRL_RCV      7
`define SSF_EVT_IDLE      0
`define SSF_RST_CTRL      8'h00
`define SSF_RST_STATUS    8'h00
`define SSF_RST_ADDR      8'h00
`define SSF_BYTE_BITS     4'h8
`endif

// File: rtl/ssf_sync.v
// Two-stage synchroniser for a bundle of pin-level inputs.
// Assumes inputs arrive asynchronously to mclk.
`timescale 1ns/1ps
module ssf_sync #(
  parameter WIDTH = 8
) (
  input  wire             mclk,    // System clock
  input  wire             nrst,    // Async reset, active low
  input  wire [WIDTH-1:0] din,     // Asynchronous inputs
  output reg  [WIDTH-1:0] dout     // Synchronised outputs
);
  reg [WIDTH-1:0] stage1;

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      stage1 <= {WIDTH{1'b0}};
      dout   <= {WIDTH{1'b0}};
    end else begin
      stage1 <= din;
      dout   <= stage1;
    end
  end
endmodule // ssf_sync

// File: rtl/ssf_status.v
// Lower status flags of a synchronous serial port (SPI or I2C):
// start-detected, direction / transmit-in-progress, address-update request, buffer full.
// Assumes link events come from the port's bit engine as pin-level strobes held at least
// three mclk cycles, and software uses the simple strobe register port.
//
// Behaviour
// - I2C start flag marks start seen last
// - Start flag cleared by reset or disable
// - Master mode: direction bit shows transmit busy
// - Idle only when busy OR enables zero
// - 10-bit mode requests address reload by software
// - Buffer full set when received byte completes
// - I2C transmit: full while data bits shift
//
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`include "ssf_map.vh"
module ssf_status (
  input  wire                   mclk,         // System clock, 40 MHz
  input  wire                   nrst,         // Async reset, active low
  input  wire [`SSF_ADDR_W-1:0] reg_addr,     // Register address
  input  wire [7:0]             reg_wdata,    // Write data
  input  wire                   reg_wr,       // Write strobe
  input  wire                   reg_rd,       // Read strobe
  output reg  [7:0]             reg_rdata,    // Read data, cycle after strobe
  input  wire                   pin_start,    // Start condition seen on bus
  input  wire                   pin_stop,     // Stop condition seen on bus
  input  wire                   pin_nack,     // Not-acknowledge seen
  input  wire                   pin_addr_hit, // Slave address byte matched
  input  wire                   pin_rw,       // R/W bit of that address byte
  input  wire                   pin_addr_hi,  // Matched byte was 10-bit high byte
  input  wire                   pin_rx_done,  // Received byte complete
  input  wire [7:0]             pin_rx_data,  // Received byte
  input  wire                   pin_tx_shift, // Data bits being shifted out
  input  wire                   pin_ack_done, // Ack sequence completed
  output wire                   port_enable,  // Port enabled
  output wire                   port_idle,    // Port idle
  output reg  [7:0]             slave_addr_reg, // Slave address for matching
  output reg                    tx_load       // Pulse: buffer written, start shifting
);
  localparam NSYNC = 10;

  reg  [7:0] ctrl;
  reg        start_seen;
  reg        dir_flag;
  reg        master_busy;
  reg        addr_update_req;
  reg        buffer_full_flag;
  reg        ack_sequence_enable;
  reg  [7:0] shift_data_buffer;
  // Transmit tracking, received-data stages and the read mux
  reg        tx_active;
  reg        shift_seen;
  reg  [7:0] rx_s1;
  reg  [7:0] pin_rx_data_q;
  reg  [7:0] next_rdata;
  reg  [NSYNC-1:0] sync_prev;
  wire [NSYNC-1:0] sync_now;
  wire [NSYNC-1:0] rise;

  ssf_sync #(.WIDTH(NSYNC)) u_sync (
    .mclk (mclk),
    .nrst (nrst),
    .din  ({pin_ack_done, pin_tx_shift, pin_rx_done, pin_addr_hi, pin_rw,
            pin_addr_hit, pin_nack, pin_stop, pin_start, 1'b0}),
    .dout (sync_now)
  );

  // Edges are taken from the synchroniser's output stage only
  // Levels come from the same stage, so rw lines up with the address hit edge
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sync_prev <= {NSYNC{1'b0}};
    end else begin
      sync_prev <= sync_now;
    end
  end
  assign rise = sync_now & ~sync_prev;

  wire ev_start  = rise[1];
  wire ev_stop   = rise[2];
  wire ev_nack   = rise[3];
  wire ev_hit    = rise[4];
  wire lvl_rw    = sync_now[5];
  wire lvl_hi    = sync_now[6];
  wire ev_rx     = rise[7];
  wire lvl_shift = sync_now[8];
  wire ev_ackd   = rise[9];

  // Mode bits from the control register
  wire en         = ctrl[`SSF_CTRL_EN];
  wire i2c_mode   = ctrl[`SSF_CTRL_I2C];
  wire master     = ctrl[`SSF_CTRL_MASTER];
  wire addr10     = ctrl[`SSF_CTRL_ADDR10];

  function is_addr;
    input [`SSF_ADDR_W-1:0] a;
    input [`SSF_ADDR_W-1:0] b;
    begin
      is_addr = (a == b);
    end
  endfunction

  // Write and read strobes decoded per register offset
  wire wr_ctrl  = reg_wr && is_addr(reg_addr, `SSF_OFF_CTRL);
  wire wr_event = reg_wr && is_addr(reg_addr, `SSF_OFF_EVENT);
  wire wr_addr  = reg_wr && is_addr(reg_addr, `SSF_OFF_ADDR);
  wire wr_buf   = reg_wr && is_addr(reg_addr, `SSF_OFF_BUF);
  wire rd_buf   = reg_rd && is_addr(reg_addr, `SSF_OFF_BUF);

  assign port_enable = en;
  // Any sequence enable still set keeps the port busy
  wire seq_active = ctrl[`SSF_CTRL_START] | ctrl[`SSF_CTRL_RSTART] | ctrl[`SSF_CTRL_STOP] |
                    ctrl[`SSF_CTRL_RCV] | ack_sequence_enable;
  assign port_idle = ~(master_busy | seq_active);

  // Control: enable, mode and sequence enables; sequence enables self-clear on the matching event
  // A software write wins over a hardware clear in the same cycle
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ctrl <= `SSF_RST_CTRL;
    end else if (wr_ctrl) begin
      ctrl <= reg_wdata;
    end else if (!en) begin
      ctrl[7:4] <= 4'h0;
    end else begin
      if (ev_start) begin
        ctrl[`SSF_CTRL_START]  <= 1'b0;
        ctrl[`SSF_CTRL_RSTART] <= 1'b0;
      end
      if (ev_stop) begin
        ctrl[`SSF_CTRL_STOP] <= 1'b0;
      end
      if (ev_rx) begin
        ctrl[`SSF_CTRL_RCV] <= 1'b0;
      end
    end
  end

  // Ack sequence enable lives in the event register, cleared by hardware when done
  // Completion wins over a new request in the same cycle
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ack_sequence_enable <= 1'b0;
    end else if (!en || ev_ackd) begin
      ack_sequence_enable <= 1'b0;
    end else if (wr_event && reg_wdata[`SSF_EVT_IDLE]) begin
      ack_sequence_enable <= 1'b1;
    end
  end

  // Start flag reflects which bus condition came last
  // A start wins over a stop seen in the same cycle
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      start_seen <= 1'b0;
    end else if (!en || !i2c_mode) begin
      start_seen <= 1'b0;
    end else if (ev_start) begin
      start_seen <= 1'b1;
    end else if (ev_stop) begin
      start_seen <= 1'b0;
    end
  end

  // Master transmit in progress: from buffer write until the ack sequence completes or a nack is seen
  // Nack ends the transfer early; the ack sequence ends it normally
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      master_busy <= 1'b0;
    end else if (!en || !i2c_mode || !master) begin
      master_busy <= 1'b0;
    end else if (wr_buf) begin
      master_busy <= 1'b1;
    end else if (ev_ackd || ev_nack) begin
      master_busy <= 1'b0;
    end
  end

  // Slave direction held from address match until stop, start or nack
  // Cleared outside slave mode so a stale direction never shows in master mode
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      dir_flag <= 1'b0;
    end else if (!en || !i2c_mode || master) begin
      dir_flag <= 1'b0;
    end else if (ev_hit) begin
      dir_flag <= lvl_rw;
    end else if (ev_stop || ev_start || ev_nack) begin
      dir_flag <= 1'b0;
    end
  end

  // Address update request; software reloads the address, which retires it.
  // A new match in the same cycle as the reload wins.
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      addr_update_req <= 1'b0;
    end else if (!en || !i2c_mode || !addr10 || master) begin
      addr_update_req <= 1'b0;
    end else if (ev_hit) begin
      addr_update_req <= 1'b1;
    end else if (wr_addr) begin
      addr_update_req <= 1'b0;
    end
  end

  // Written only by software; the match logic outside reads it
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      slave_addr_reg <= `SSF_RST_ADDR;
    end else if (wr_addr) begin
      slave_addr_reg <= reg_wdata;
    end
  end

  // Buffer full: receive completion sets it, a buffer read clears it; in I2C
  // transmit it follows the data shifting, excluding ack and stop phases.
  // A receive completion wins over a buffer read in the same cycle
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      buffer_full_flag <= 1'b0;
      shift_data_buffer <= 8'h00;
      tx_load <= 1'b0;
    end else begin
      tx_load <= 1'b0;
      if (!en) begin
        buffer_full_flag <= 1'b0;
      end else if (ev_rx) begin
        buffer_full_flag  <= 1'b1;
        shift_data_buffer <= pin_rx_data_q;
      end else if (wr_buf && i2c_mode) begin
        buffer_full_flag  <= 1'b1;
        shift_data_buffer <= reg_wdata;
        tx_load           <= 1'b1;
      end else if (rd_buf) begin
        buffer_full_flag <= 1'b0;
      end else if (i2c_mode && tx_active && !lvl_shift && shift_seen) begin
        buffer_full_flag <= 1'b0;
      end
    end
  end

  // Transmit tracking: clear full once shifting has been seen to end
  // Cleared only after shifting was seen, so a load not yet taken up stays full
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tx_active  <= 1'b0;
      shift_seen <= 1'b0;
    end else if (!en || (tx_active && shift_seen && !lvl_shift)) begin
      tx_active  <= 1'b0;
      shift_seen <= 1'b0;
    end else if (wr_buf && i2c_mode) begin
      tx_active  <= 1'b1;
      shift_seen <= 1'b0;
    end else if (tx_active && lvl_shift) begin
      shift_seen <= 1'b1;
    end
  end

  // Received data is stable while rx_done is high; sample it through two stages too
  // The synchronised copy lines up with the synchronised done edge
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rx_s1         <= 8'h00;
      pin_rx_data_q <= 8'h00;
    end else begin
      rx_s1         <= pin_rx_data;
      pin_rx_data_q <= rx_s1;
    end
  end

  // Bit 2 shows transmit progress in master mode and the captured direction in slave mode
  wire       status_dir = master ? master_busy : dir_flag;
  wire [7:0] evt_rdata  = {6'h00, port_idle, ack_sequence_enable};
  wire [7:0] status     = {4'h0, start_seen, status_dir, addr_update_req, buffer_full_flag};

  // Read data stands only in the cycle after the strobe; unmapped reads give zero
  always @* begin
    next_rdata = 8'h00;
    if (!reg_rd) begin
      next_rdata = 8'h00;
    end else if (is_addr(reg_addr, `SSF_OFF_STATUS)) begin
      next_rdata = status;
    end else if (is_addr(reg_addr, `SSF_OFF_CTRL)) begin
      next_rdata = ctrl;
    end else if (is_addr(reg_addr, `SSF_OFF_EVENT)) begin
      next_rdata = evt_rdata;
    end else if (is_addr(reg_addr, `SSF_OFF_ADDR)) begin
      next_rdata = slave_addr_reg;
    end else if (is_addr(reg_addr, `SSF_OFF_BUF)) begin
      next_rdata = shift_data_buffer;
    end
  end

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_rdata;
    end
  end
endmodule // ssf_status

// File: sim/ssf_status_props.sv
// Port-level checker for the serial port status flags block.
// Assumes one system clock and the async active-low reset of the block.
`timescale 1ns/1ps
module ssf_status_props (
  input wire       mclk,           // System clock
  input wire       nrst,           // Async reset, active low
  input wire [3:0] reg_addr,       // Register address
  input wire [7:0] reg_wdata,      // Write data
  input wire       reg_wr,         // Write strobe
  input wire       reg_rd,         // Read strobe
  input wire [7:0] reg_rdata,      // Read data
  input wire       port_enable,    // Port enabled
  input wire [7:0] slave_addr_reg, // Slave address
  input wire       tx_load         // Buffer load pulse
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data not cleared");
  a_unmapped_read: assert property (reg_rd && reg_addr > 4'h4 |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  a_status_upper: assert property (reg_rd && reg_addr == 4'h0 |=> reg_rdata[7:4] == 4'h0) else $error("status upper bits set");
  a_enable_write: assert property (reg_wr && reg_addr == 4'h1 |=> port_enable == $past(reg_wdata[0])) else $error("enable not written");
  a_enable_hold: assert property (!$past(reg_wr) |-> $stable(port_enable)) else $error("enable moved without write");
  a_addr_change: assert property ($changed(slave_addr_reg) |-> $past(reg_wr) && $past(reg_addr) == 4'h3) else
    $error("slave address moved without write");
  a_load_pulse: assert property (tx_load && !(reg_wr && reg_addr == 4'h4) |=> !tx_load) else
    $error("load pulse too long");
  a_load_cause: assert property (tx_load |-> $past(reg_wr) && $past(reg_addr) == 4'h4) else
    $error("load pulse without buffer write");
  a_start_off: assert property (reg_rd && reg_addr == 4'h0 && !port_enable && !$past(port_enable) |=>
    !reg_rdata[3]) else $error("start flag set while disabled");
endmodule // ssf_status_props
bind ssf_status ssf_status_props chk_u (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .port_enable(port_enable),
  .slave_addr_reg(slave_addr_reg), .tx_load(tx_load));

// File: sim/ssf_peer.sv
// Far-side model: the bit engine's event pins as a serial peer would cause them.
// Assumes one event at a time, held long enough for the two-flop synchroniser.
`timescale 1ns/1ps
module ssf_peer (
  input  wire       mclk,        // System clock
  output reg  [7:0] pin_rx_data, // Received byte
  output reg        pin_rw,      // R/W bit of address byte
  output reg  [7:0] ev           // {ack,tx,rx,hi,hit,nack,stop,start}
);
  initial begin
    ev = 8'h00;
    pin_rx_data = 8'h00;
    pin_rw = 1'b0;
  end
  task send(input int b, input logic [7:0] d);
    @(posedge mclk);
    pin_rx_data <= d;
    pin_rw <= d[0];
    ev[b] <= 1'b1;
    if (b == 3) ev[4] <= 1'b1;
    repeat (4) @(posedge mclk);
    // Shift ends before ack and stop phases
    ev <= 8'h00;
    // Released byte no longer holds its value
    pin_rx_data <= ~d;
    pin_rw <= ~d[0];
    repeat (3) @(posedge mclk);
  endtask
endmodule // ssf_peer

// File: sim/tb_ssf_status.sv
// Self-checking bench for the status flags block with an integer flag model.
// Assumes the peer model drives all link events.
`timescale 1ns/1ps
`include "ssf_map.vh"
module tb_ssf_status;
  reg         mclk = 1'b0;
  reg         nrst = 1'b0;
  reg         reg_wr = 1'b0;
  reg         reg_rd = 1'b0;
  reg   [3:0] reg_addr = 4'h0;
  reg   [7:0] reg_wdata = 8'h00;
  reg   [7:0] rd;
  reg   [7:0] r;
  reg         load_seen = 1'b0;
  wire  [7:0] reg_rdata, slave_addr_reg, pin_rx_data, ev;
  wire        pin_rw, port_enable, port_idle, tx_load;
  integer     fail_count = 0, compares = 0, st = 0, dir = 0, ua = 0, bf = 0;
  always #12.5 mclk = ~mclk;
  always @(posedge mclk) if (tx_load === 1'b1) load_seen <= 1'b1;
  ssf_peer peer_u (.mclk(mclk), .pin_rx_data(pin_rx_data), .pin_rw(pin_rw), .ev(ev));
  ssf_status dut_u (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_start(ev[0]), .pin_stop(ev[1]), .pin_nack(ev[2]),
    .pin_addr_hit(ev[3]), .pin_rw(pin_rw), .pin_addr_hi(ev[4]), .pin_rx_done(ev[5]), .pin_rx_data(pin_rx_data),
    .pin_tx_shift(ev[6]), .pin_ack_done(ev[7]), .port_enable(port_enable), .port_idle(port_idle),
    .slave_addr_reg(slave_addr_reg), .tx_load(tx_load));
  task chk(input [7:0] got, input [7:0] exp);
    compares = compares + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input [3:0] a, input [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task rdreg(input [3:0] a);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask
  task cks;
    rdreg(`SSF_OFF_STATUS);
    chk(rd, {4'h0, st[0], dir[0], ua[0], bf[0]});
  endtask
  task results;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #200000;
    fail_count = fail_count + 1;
    results;
  end
  initial begin
    void'($urandom(32'h0CEA));
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    cks;
    wr(`SSF_OFF_CTRL, 8'h0B);
    peer_u.send(0, 8'h00);
    st = 1;
    cks;
    r = $urandom;
    peer_u.send(3, {r[7:1], 1'b1});
    dir = 1;
    ua = 1;
    cks;
    wr(`SSF_OFF_ADDR, r);
    ua = 0;
    cks;
    chk(slave_addr_reg, r);
    r = $urandom;
    peer_u.send(5, r);
    bf = 1;
    cks;
    rdreg(`SSF_OFF_BUF);
    chk(rd, r);
    bf = 0;
    peer_u.send(2, 8'h00);
    dir = 0;
    cks;
    peer_u.send(1, 8'h00);
    st = 0;
    cks;
    $display("slave test done");
    peer_u.send(0, 8'h00);
    wr(`SSF_OFF_CTRL, 8'h00);
    cks;
    $display("disable test done");
    wr(`SSF_OFF_CTRL, 8'h07);
    rdreg(`SSF_OFF_EVENT);
    chk({7'h00, rd[1]}, 8'h01);
    r = $urandom;
    wr(`SSF_OFF_BUF, r);
    dir = 1;
    bf = 1;
    cks;
    chk({6'h00, load_seen, port_idle}, 8'h02);
    peer_u.send(6, 8'h00);
    bf = 0;
    cks;
    peer_u.send(7, 8'h00);
    dir = 0;
    cks;
    chk({7'h00, port_idle}, 8'h01);
    wr(`SSF_OFF_EVENT, 8'h01);
    chk({7'h00, port_idle}, 8'h00);
    peer_u.send(7, 8'h00);
    chk({7'h00, port_idle}, 8'h01);
    wr(`SSF_OFF_CTRL, 8'h17);
    chk({7'h00, port_idle}, 8'h00);
    peer_u.send(0, 8'h00);
    chk({7'h00, port_idle}, 8'h01);
    $display("master test done");
    wr(`SSF_OFF_CTRL, 8'h01);
    r = $urandom;
    peer_u.send(5, r);
    bf = 1;
    cks;
    rdreg(4'hF);
    chk(rd, 8'h00);
    $display("spi test done");
    results;
  end
endmodule // tb_ssf_status
